/* File: hw/obcd_field_decode.v */
// Purpose: Combinational decode of the option fields into clock and sector settings.
// Assumes: Inputs already captured and stable.
// Notes:   Reserved range code, with rc_off set, selects no clock source and flags an error.
`timescale 1ns/1ns
`include "obcd_consts.vh"
module obcd_field_decode (
	input  wire [2:0]  osc_range_select,   // Range field
	input  wire [1:0]  sector_zero_size,   // Sector field
	input  wire        rc_off,             // Internal RC oscillator deselected
	output reg  [4:0]  range_onehot,       // lp, mp, ms, hs, watch
	output reg  [1:0]  ext_clk_sel,        // bit0 osc pin, bit1 port pin
	output reg         range_bad,          // Reserved code in use
	output wire [12:0] sector_bytes        // Sector zero size in bytes
);
	always @* begin
		range_onehot = 5'h00;
		ext_clk_sel  = 2'h0;
		range_bad    = 1'b0;
		if (rc_off) begin
			case (osc_range_select)
				`OBCD_RANGE_LP:       range_onehot = 5'h01;
				`OBCD_RANGE_MP:       range_onehot = 5'h02;
				`OBCD_RANGE_MS:       range_onehot = 5'h04;
				`OBCD_RANGE_HS:       range_onehot = 5'h08;
				`OBCD_RANGE_WATCH:    range_onehot = 5'h10;
				`OBCD_RANGE_EXT_OSC:  ext_clk_sel  = 2'h1;
				`OBCD_RANGE_EXT_PORT: ext_clk_sel  = 2'h2;
				default:              range_bad    = 1'b1;
			endcase
		end
	end
	assign sector_bytes = `OBCD_SEC_BYTES_0K5 << sector_zero_size;
endmodule // obcd_field_decode

/* File: hw/obcd_option_byte_zero.v */
// Purpose: Holds option byte zero, allows programming access, and exports static settings.
// Assumes: Option byte one RC select bit may change off mclk, so it is synchronised.
// Notes:   Settings are captured on reset release and then frozen.
//
// Contract
// - Option bytes are read or written only in programming mode.
// - Range field is used only while the internal RC oscillator is off; the start-up delay also reads it with RC on.
// - Range codes map to four resonator ranges, watch crystal, two external clocks.
// - Sector field gives 0.5k, 1k, 2k or 4k bytes.
// - Stored byte is erased value ff until programmed.
// - Option byte one select bit: zero RC on, one RC off.
`timescale 1ns/1ns
`include "obcd_consts.vh"
module obcd_option_byte_zero (
	input  wire        mclk,               // System clock, 100 MHz
	input  wire        rst_b,              // Asynchronous reset, active low
	input  wire        prog_mode,          // Programming mode pin, asynchronous
	input  wire        opt_wr,             // Write strobe from programmer
	input  wire        opt_rd,             // Read strobe from programmer
	input  wire [7:0]  opt_wdata,          // Write data
	input  wire        rc_osc_select,      // Option byte one RC select bit
	output reg  [7:0]  opt_rdata,          // Read data, zero outside reads
	output reg  [2:0]  osc_range_select,   // Captured range field
	output reg  [1:0]  sector_zero_size,   // Captured sector field
	output reg         internal_rc_on,     // Internal RC oscillator enabled
	output reg  [4:0]  range_onehot,       // Resonator range selection
	output reg  [1:0]  ext_clk_sel,        // External clock input selection
	output reg         range_bad,          // Reserved range code captured with RC off
	output reg  [12:0] sector_bytes,       // Sector zero size in bytes
	output reg  [11:0] startup_cycles,     // Start-up delay, valid with RC on
	output reg         reserved_top_bit    // Stored reserved bit
);
	// ----------------------------------------------------------------
	// Capture states and field helpers
	// ----------------------------------------------------------------
	// One-hot capture states: load once after reset, then hold.
	localparam [1:0] CAP_LOAD = 2'b01;
	localparam [1:0] CAP_HOLD = 2'b10;

	function [2:0] range_field(input [7:0] opt_byte);
		range_field = opt_byte[`OBCD_RANGE_MSB:`OBCD_RANGE_LSB];
	endfunction

	function [1:0] sector_field(input [7:0] opt_byte);
		sector_field = opt_byte[`OBCD_SEC_MSB:`OBCD_SEC_LSB];
	endfunction

	// The long start-up delay belongs to the RC oscillator with the default
	// range field; a resonator or external clock gets no delay from here.
	function [11:0] startup_delay(input rc_on, input [2:0] range_sel);
		startup_delay = (rc_on && range_sel == `OBCD_RANGE_DEFAULT) ?
			`OBCD_STARTUP_CYCLES : 12'h000;
	endfunction

	// ----------------------------------------------------------------
	// Programming mode synchroniser
	// ----------------------------------------------------------------
	reg        prog_meta;
	reg        prog_sync;

	// Reset drops programming access, so mode entry is seen again only
	// two edges after reset release.
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			prog_meta <= 1'b0;
			prog_sync <= 1'b0;
		end else begin
			prog_meta <= prog_mode;
			prog_sync <= prog_meta;
		end
	end

	// ----------------------------------------------------------------
	// Oscillator select synchroniser
	// ----------------------------------------------------------------
	reg        rc_meta;
	reg        rc_sync;

	// Kept out of reset on purpose: it settles while reset is held, so the
	// capture edge sees the real select bit and not a reset value.
	always @(posedge mclk) begin
		rc_meta <= rc_osc_select;
		rc_sync <= rc_meta;
	end

	// ----------------------------------------------------------------
	// Option byte storage and programming access
	// ----------------------------------------------------------------
	// Reset does not erase the byte, as in the non-volatile array; only
	// power-up starts from the erased value.
	reg  [7:0] hardware_option_byte_zero = `OBCD_ERASED_VALUE;
	reg  [7:0] next_option_byte;
	reg  [7:0] next_opt_rdata;
	wire       wr_take = prog_sync & opt_wr;
	wire       rd_take = prog_sync & opt_rd;

	always @* begin
		next_option_byte = hardware_option_byte_zero;
		if (wr_take) begin
			// The reserved bit is forced high so a careless write cannot clear it.
			next_option_byte = opt_wdata | 8'h80;
		end
	end

	always @(posedge mclk) begin
		hardware_option_byte_zero <= next_option_byte;
	end

	always @* begin
		next_opt_rdata = 8'h00;
		if (rd_take) begin
			next_opt_rdata = hardware_option_byte_zero;
		end
	end

	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			opt_rdata <= 8'h00;
		end else begin
			opt_rdata <= next_opt_rdata;
		end
	end

	// ----------------------------------------------------------------
	// Field decode
	// ----------------------------------------------------------------
	wire [4:0]  dec_onehot;
	wire [1:0]  dec_ext;
	wire        dec_bad;
	wire [12:0] dec_bytes;
	wire [2:0]  stored_range = range_field(hardware_option_byte_zero);
	wire [1:0]  stored_sec   = sector_field(hardware_option_byte_zero);

	obcd_field_decode obcd_field_decode_i (
		.osc_range_select (stored_range),
		.sector_zero_size (stored_sec),
		.rc_off           (rc_sync),
		.range_onehot     (dec_onehot),
		.ext_clk_sel      (dec_ext),
		.range_bad        (dec_bad),
		.sector_bytes     (dec_bytes)
	);

	// ----------------------------------------------------------------
	// Values offered for capture
	// ----------------------------------------------------------------
	wire [2:0]  next_osc_range_select = stored_range;
	wire [1:0]  next_sector_zero_size = stored_sec;
	wire        next_internal_rc_on   = ~rc_sync;
	wire [4:0]  next_range_onehot     = dec_onehot;
	wire [1:0]  next_ext_clk_sel      = dec_ext;
	wire        next_range_bad        = dec_bad;
	wire [12:0] next_sector_bytes     = dec_bytes;
	wire [11:0] next_startup_cycles   = startup_delay(~rc_sync, stored_range);
	wire        next_reserved_top_bit = hardware_option_byte_zero[`OBCD_RSV_BIT];

	// ----------------------------------------------------------------
	// Capture sequencing
	// ----------------------------------------------------------------
	reg  [1:0]  cap_state;
	reg  [1:0]  next_cap_state;
	reg         cap_load;

	always @* begin
		next_cap_state = cap_state;
		cap_load       = 1'b0;
		case (cap_state)
			CAP_LOAD: begin
				cap_load       = 1'b1;
				next_cap_state = CAP_HOLD;
			end
			CAP_HOLD: begin
				next_cap_state = CAP_HOLD;
			end
			// A corrupted state must not reload mid-run, so it falls to hold.
			default: begin
				next_cap_state = CAP_HOLD;
			end
		endcase
	end

	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cap_state <= CAP_LOAD;
		end else begin
			cap_state <= next_cap_state;
		end
	end

	// ----------------------------------------------------------------
	// Captured outputs
	// ----------------------------------------------------------------
	// Loaded on the first edge after reset release; later writes to the
	// byte only take effect at the next reset.
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			osc_range_select <= `OBCD_RANGE_DEFAULT;
			internal_rc_on   <= 1'b0;
			range_onehot     <= 5'h00;
			ext_clk_sel      <= 2'h0;
			range_bad        <= 1'b0;
			startup_cycles   <= 12'h000;
		end else if (cap_load) begin
			osc_range_select <= next_osc_range_select;
			internal_rc_on   <= next_internal_rc_on;
			range_onehot     <= next_range_onehot;
			ext_clk_sel      <= next_ext_clk_sel;
			range_bad        <= next_range_bad;
			startup_cycles   <= next_startup_cycles;
		end
	end

	// Sector settings feed the flash protection logic and share the capture.
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sector_zero_size <= `OBCD_SEC_4K;
			sector_bytes     <= 13'h0000;
			reserved_top_bit <= 1'b1;
		end else if (cap_load) begin
			sector_zero_size <= next_sector_zero_size;
			sector_bytes     <= next_sector_bytes;
			reserved_top_bit <= next_reserved_top_bit;
		end
	end
endmodule // obcd_option_byte_zero

/* File: inc/obcd_consts.vh */
// Purpose: Constants for the option byte zero configuration decoder.
// Assumes: Byte layout as stored in non-volatile memory.
// Notes:   Definitions only.
`ifndef OBCD_CONSTS_VH
`define OBCD_CONSTS_VH
`define OBCD_ERASED_VALUE   8'hff
`define OBCD_RSV_BIT        7
`define OBCD_RANGE_MSB      6
`define OBCD_RANGE_LSB      4
`define OBCD_SEC_MSB        3
`define OBCD_SEC_LSB        2
`define OBCD_RANGE_LP       3'h0
`define OBCD_RANGE_MP       3'h1
`define OBCD_RANGE_MS       3'h2
`define OBCD_RANGE_HS       3'h3
`define OBCD_RANGE_WATCH    3'h4
`define OBCD_RANGE_EXT_OSC  3'h5
`define OBCD_RANGE_RSV      3'h6
`define OBCD_RANGE_EXT_PORT 3'h7
`define OBCD_RANGE_DEFAULT  3'h7
`define OBCD_SEC_0K5        2'h0
`define OBCD_SEC_1K         2'h1
`define OBCD_SEC_2K         2'h2
`define OBCD_SEC_4K         2'h3
`define OBCD_STARTUP_CYCLES 12'h100
`define OBCD_SEC_BYTES_0K5  13'h0200
`endif

/* File: verif/obcd_checker.sv */
// Purpose: Port assertions for the option byte zero decoder.
// Assumes: Decoded outputs settle one edge after reset release.
// Notes:   Bound from the bench top file.
`timescale 1ns/1ns
module obcd_checker (
	input wire logic        mclk,             // Clock
	input wire logic        rst_b,            // Reset, active low
	input wire logic        opt_rd,           // Read strobe
	input wire logic [7:0]  opt_rdata,        // Read data
	input wire logic [2:0]  osc_range_select, // Range field
	input wire logic [1:0]  sector_zero_size, // Sector field
	input wire logic        internal_rc_on,   // RC enabled
	input wire logic [4:0]  range_onehot,     // Resonator range
	input wire logic [1:0]  ext_clk_sel,      // External clock
	input wire logic        range_bad,        // Reserved code
	input wire logic [12:0] sector_bytes,     // Sector bytes
	input wire logic [11:0] startup_cycles    // Start-up delay
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	sequence s_read_hit;
		opt_rd ##1 (opt_rdata != 8'h00);
	endsequence
	a_sector_size_map: assert property ($past(rst_b) |->
		sector_bytes == (13'h0200 << sector_zero_size)) else $error("sector size wrong");
	a_rc_on_quiet: assert property (internal_rc_on |->
		range_onehot == 5'h00 && ext_clk_sel == 2'h0 && !range_bad) else $error("range used");
	a_range_onehot_map: assert property ($past(rst_b) && !internal_rc_on
		&& osc_range_select < 3'h5 |-> range_onehot == 5'h01 << osc_range_select)
		else $error("range decode wrong");
	a_ext_source_map: assert property ($past(rst_b) && !internal_rc_on |->
		ext_clk_sel == {osc_range_select == 3'h7, osc_range_select == 3'h5}
		&& range_bad == (osc_range_select == 3'h6)) else $error("external source wrong");
	a_startup_default: assert property ($past(rst_b) |-> startup_cycles ==
		(internal_rc_on && osc_range_select == 3'h7 ? 12'h100 : 12'h000))
		else $error("start-up delay wrong");
	a_config_held: assert property ($past(rst_b) |=>
		$stable({osc_range_select, sector_zero_size, internal_rc_on})) else $error("config moved");
	a_read_idle_zero: assert property (!$past(opt_rd) |-> opt_rdata == 8'h00)
		else $error("read data outside read");
	a_read_top_set: assert property (s_read_hit |-> opt_rdata[7])
		else $error("top bit clear");
endmodule // obcd_checker

/* File: verif/obcd_prog_tool.sv */
// Purpose: Programming tool model driving the option byte port.
// Assumes: Signals change 1 ns after a rising edge.
// Notes:   Idle data lines show the inverse of the last byte.
`timescale 1ns/1ns
module obcd_prog_tool (
	input  wire logic       mclk,              // Clock
	output logic            prog_mode = 1'b0,  // Programming mode
	output logic            opt_wr = 1'b0,     // Write strobe
	output logic            opt_rd = 1'b0,     // Read strobe
	output logic [7:0]      opt_wdata = 8'h00, // Write data
	input  wire logic [7:0] opt_rdata          // Read data
);
	task automatic mode(input logic m);
		@(posedge mclk) #1;
		prog_mode = m;
		repeat (3) @(posedge mclk);
	endtask
	task automatic wr(input logic [7:0] d);
		@(posedge mclk) #1;
		opt_wr = 1'b1;
		opt_wdata = d | 8'h80;
		@(posedge mclk) #1;
		opt_wr = 1'b0;
		opt_wdata = ~opt_wdata;
	endtask
	task automatic rd(output logic [7:0] q);
		@(posedge mclk) #1;
		opt_rd = 1'b1;
		@(posedge mclk) #1;
		opt_rd = 1'b0;
		q = opt_rdata;
	endtask
endmodule // obcd_prog_tool

/* File: verif/test_option_byte_config_decoder.sv */
// Purpose: Self-checking bench for the option byte zero decoder.
// Assumes: Seeded random bytes plus fixed corner cases.
// Notes:   Each pass programs a byte, resets, then checks the decode.
`timescale 1ns/1ns
module test_option_byte_config_decoder;
	logic        mclk = 1'b0, rst_b = 1'b0, rc_osc_select = 1'b1;
	logic        prog_mode, opt_wr, opt_rd, range_bad, internal_rc_on, reserved_top_bit;
	logic [7:0]  opt_wdata, opt_rdata, q, b;
	logic [2:0]  osc_range_select;
	logic [1:0]  sector_zero_size, ext_clk_sel;
	logic [4:0]  range_onehot;
	logic [12:0] sector_bytes;
	logic [11:0] startup_cycles;
	logic [39:0] e;
	int          num_errors = 0, tests_run = 0, cycles = 0;
	wire  [39:0] cfg = {internal_rc_on, osc_range_select, sector_zero_size, reserved_top_bit,
		range_onehot, ext_clk_sel, range_bad, sector_bytes, startup_cycles};
	obcd_option_byte_zero obcd_option_byte_zero_i (.mclk(mclk), .rst_b(rst_b),
		.prog_mode(prog_mode), .opt_wr(opt_wr), .opt_rd(opt_rd), .opt_wdata(opt_wdata),
		.rc_osc_select(rc_osc_select), .opt_rdata(opt_rdata),
		.osc_range_select(osc_range_select), .sector_zero_size(sector_zero_size),
		.internal_rc_on(internal_rc_on), .range_onehot(range_onehot),
		.ext_clk_sel(ext_clk_sel), .range_bad(range_bad), .sector_bytes(sector_bytes),
		.startup_cycles(startup_cycles), .reserved_top_bit(reserved_top_bit));
	obcd_prog_tool obcd_prog_tool_i (.mclk(mclk), .prog_mode(prog_mode), .opt_wr(opt_wr),
		.opt_rd(opt_rd), .opt_wdata(opt_wdata), .opt_rdata(opt_rdata));
	initial forever #5 mclk = ~mclk;
	function automatic logic [39:0] decode(input logic [7:0] v, input logic on);
		decode = {on, v[6:4], v[3:2], 1'b1, on || v[6:4] > 3'h4 ? 5'h00 : 5'h01 << v[6:4],
			on ? 2'h0 : {v[6:4] == 3'h7, v[6:4] == 3'h5}, !on && v[6:4] == 3'h6,
			13'h0200 << v[3:2], on && v[6:4] == 3'h7 ? 12'h100 : 12'h000};
	endfunction
	task automatic check(input logic [39:0] seen, input logic [39:0] want);
		tests_run++;
		if (seen !== want) begin
			num_errors++;
			$display("ERROR %0t seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic finish_test;
		if (num_errors == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic reset_check(input logic [7:0] v);
		@(posedge mclk) #1;
		rst_b = 1'b0;
		repeat (3) @(posedge mclk);
		#1 rst_b = 1'b1;
		repeat (3) @(posedge mclk);
		e = decode(v, !rc_osc_select);
		#1 check(cfg, e);
	endtask
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			finish_test;
		end
	end
	initial begin
		b = $urandom(87);
		reset_check(8'hff);
		obcd_prog_tool_i.mode(1'b1);
		for (int i = 0; i < 14; i++) begin
			b = $urandom;
			rc_osc_select = i < 8 || $urandom_range(1);
			if (i < 8) b[6:4] = i[2:0];
			if (!rc_osc_select) b[6:4] = 3'h7;
			obcd_prog_tool_i.wr(b);
			obcd_prog_tool_i.rd(q);
			check({32'h0, q}, {32'h0, b | 8'h80});
			check(cfg, e);
			reset_check(b);
		end
		obcd_prog_tool_i.mode(1'b0);
		obcd_prog_tool_i.wr(~b);
		obcd_prog_tool_i.rd(q);
		check({32'h0, q}, 40'h0);
		reset_check(b);
		finish_test;
	end
endmodule // test_option_byte_config_decoder
bind obcd_option_byte_zero obcd_checker obcd_checker_i (.mclk(mclk), .rst_b(rst_b),
	.opt_rd(opt_rd), .opt_rdata(opt_rdata), .osc_range_select(osc_range_select),
	.sector_zero_size(sector_zero_size), .internal_rc_on(internal_rc_on),
	.range_onehot(range_onehot), .ext_clk_sel(ext_clk_sel), .range_bad(range_bad),
	.sector_bytes(sector_bytes), .startup_cycles(startup_cycles));
